// >>> rtl/eiv_defines.svh
`ifndef EIV_DEFINES_SVH
`define EIV_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define EIV_IDX_PRIO0 8'h24
`define EIV_IDX_PRIO1 8'h25
`define EIV_IDX_PRIO2 8'h26
`define EIV_IDX_PRIO3 8'h27
`define EIV_IDX_SENSE 8'h28
`define EIV_IDX_STATUS 8'h29
`define EIV_IDX_MASK 8'h2a

// ----------------------------------------------------------------
// reset values and fixed fields
// ----------------------------------------------------------------
`define EIV_PRIO_RESET 8'hff
`define EIV_PRIO0_FIXED 8'h03
`define EIV_PRIO3_FIXED 8'hf0
`define EIV_PRIO_NOFIX 8'h00
`define EIV_SENSE_RESET 8'h00
`define EIV_SENSE_WMASK 8'hfc
`define EIV_LEVEL0_PAIR 2'b10
`define EIV_CORE_LOCKED 2'b11

// ----------------------------------------------------------------
// sense control field positions
// ----------------------------------------------------------------
`define EIV_PB_SENSE_HI 7
`define EIV_PB_SENSE_LO 6
`define EIV_PB_INV 5
`define EIV_PA_SENSE_HI 4
`define EIV_PA_SENSE_LO 3
`define EIV_PA_INV 2

// ----------------------------------------------------------------
// vectors (lower address of each pair) and halt wake set
// ----------------------------------------------------------------
`define EIV_VEC_CLK_TB 16'hfff8
`define EIV_VEC_PORTA 16'hfff6
`define EIV_VEC_PORTF 16'hfff4
`define EIV_VEC_PORTB_LOW 16'hfff2
`define EIV_VEC_PORTB_HIGH 16'hfff0
`define EIV_VEC_SPI 16'hffec
`define EIV_VEC_TIMER_A 16'hffea
`define EIV_VEC_TIMER_B 16'hffe8
`define EIV_VEC_SCI 16'hffe6
`define EIV_VEC_AUX_VD 16'hffe4
`define EIV_WAKE_SET 10'h03f

`endif

// >>> rtl/eiv_pkg.sv
package eiv_pkg;

  typedef enum logic [1:0] {
    EIV_SENSE_FALL_LOW = 2'b00,
    EIV_SENSE_RISE = 2'b01,
    EIV_SENSE_FALL = 2'b10,
    EIV_SENSE_BOTH = 2'b11
  } eiv_sense_t;

  // source index doubles as fixed hardware order, 0 is served first
  typedef enum logic [3:0] {
    EIV_SRC_CLK_TB = 4'h0,
    EIV_SRC_PORTA = 4'h1,
    EIV_SRC_PORTF = 4'h2,
    EIV_SRC_PORTB_LOW = 4'h3,
    EIV_SRC_PORTB_HIGH = 4'h4,
    EIV_SRC_SPI = 4'h5,
    EIV_SRC_TIMER_A = 4'h6,
    EIV_SRC_TIMER_B = 4'h7,
    EIV_SRC_SCI = 4'h8,
    EIV_SRC_AUX_VD = 4'h9
  } eiv_src_t;

  typedef enum logic [2:0] {
    EIV_REG_PRIO0 = 3'h0,
    EIV_REG_PRIO1 = 3'h1,
    EIV_REG_PRIO2 = 3'h2,
    EIV_REG_PRIO3 = 3'h3,
    EIV_REG_SENSE = 3'h4,
    EIV_REG_STATUS = 3'h5,
    EIV_REG_MASK = 3'h6,
    EIV_REG_NONE = 3'h7
  } eiv_reg_t;

endpackage

// >>> rtl/eiv_ctrl.sv
`timescale 1ns/100ps
`include "eiv_defines.svh"

// Notes on behaviour
// - port B low, no inversion: 00 fall+low, 01 rise, 10 fall, 11 both.
// - port B low inverted: 00 rise+high, 01 fall, 10 rise, 11 both.
// - port B high uses port B code, never inverted.
// - port A uses second code, inversion bit flips it like port B low.
// - port F uses port A code, never inverted.
// - priority pairs reset to 11; prio0 bits 1:0 and prio3 bits 7:4 always read one.
// - equal software priority resolved by fixed order, clock base first.
// - clock time base vectors to fff8, wakes from halt.
// - external lines vector fff6/fff4/fff2/fff0, all wake from halt.
// - spi vectors to ffec and wakes from halt.
// - timers, sci and voltage detector never wake from halt.
// - sense bits writable only while core priority is level 3.
// - changing a sense or polarity setting clears affected pending lines.
// - a pair written as level 0 keeps its previous value.
module eiv_ctrl
  import eiv_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NSRC = 10
)
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic PORTA_LINE,
  input wire logic PORTF_LINE,
  input wire logic PORTB_LOW_LINE,
  input wire logic PORTB_HIGH_LINE,
  input wire logic [1:0] CORE_COND_CODE,
  input wire logic CLK_TIME_BASE_REQ,
  input wire logic SPI_REQ,
  input wire logic TIMER_A_REQ,
  input wire logic TIMER_B_REQ,
  input wire logic SCI_REQ,
  input wire logic AUX_VOLTAGE_REQ,
  input wire logic IRQ_ACK,
  output logic IRQ_REQ,
  output logic [15:0] IRQ_VECTOR,
  output logic [1:0] IRQ_LEVEL,
  output logic WAKE_REQ,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input eiv_sense_t code, input logic inv,
                                    input logic cur, input logic prev);
    logic fall;
    logic rise;
    fall = prev & ~cur;
    rise = ~prev & cur;
    case (code)
      EIV_SENSE_FALL_LOW: edge_hit = inv ? rise : fall;
      EIV_SENSE_RISE: edge_hit = inv ? fall : rise;
      EIV_SENSE_FALL: edge_hit = inv ? rise : fall;
      default: edge_hit = fall | rise;
    endcase
  endfunction

  // numeric level: 10 -> 0, 01 -> 1, 00 -> 2, 11 -> 3
  function automatic logic [1:0] level_of(input logic [1:0] pair);
    case (pair)
      2'b10: level_of = 2'd0;
      2'b01: level_of = 2'd1;
      2'b00: level_of = 2'd2;
      default: level_of = 2'd3;
    endcase
  endfunction

  function automatic logic [7:0] prio_write(input logic [7:0] old, input logic [7:0] wdat,
                                            input logic [7:0] fixed);
    logic [7:0] res;
    res = wdat;
    for (int p = 0; p < 4; p++)
    begin
      if (wdat[2*p +: 2] == `EIV_LEVEL0_PAIR)
      begin
        res[2*p +: 2] = old[2*p +: 2];
      end
    end
    prio_write = res | fixed;
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] src);
    case (src)
      EIV_SRC_CLK_TB: vec_of = `EIV_VEC_CLK_TB;
      EIV_SRC_PORTA: vec_of = `EIV_VEC_PORTA;
      EIV_SRC_PORTF: vec_of = `EIV_VEC_PORTF;
      EIV_SRC_PORTB_LOW: vec_of = `EIV_VEC_PORTB_LOW;
      EIV_SRC_PORTB_HIGH: vec_of = `EIV_VEC_PORTB_HIGH;
      EIV_SRC_SPI: vec_of = `EIV_VEC_SPI;
      EIV_SRC_TIMER_A: vec_of = `EIV_VEC_TIMER_A;
      EIV_SRC_TIMER_B: vec_of = `EIV_VEC_TIMER_B;
      EIV_SRC_SCI: vec_of = `EIV_VEC_SCI;
      default: vec_of = `EIV_VEC_AUX_VD;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] prio [0:3];
  logic [7:0] pin_irq_sense_ctrl;
  logic [3:0] pin_prev;
  logic [3:0] ext_pend;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] irq_src;
  logic pready;
  logic [3:0] pins;
  logic [3:0] ext_edge;
  logic [3:0] ext_level;
  logic [3:0] sense_clr;
  logic [NSRC-1:0] req;
  logic [1:0] src_pair [0:NSRC-1];
  logic found;
  logic [1:0] best_lvl;
  logic [3:0] best_src;
  logic take;
  eiv_reg_t reg_sel;
  logic apb_commit;
  logic wr;
  logic sense_wr_ok;
  logic [7:0] sense_new;
  logic [31:0] next_prdata;
  logic [3:0] next_status;
  logic [3:0] next_mask;

  // ----------------------------------------------------------------
  // apb decode and read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    case (PADDR[ADDR_W-1:2])
      (ADDR_W-2)'(`EIV_IDX_PRIO0): reg_sel = EIV_REG_PRIO0;
      (ADDR_W-2)'(`EIV_IDX_PRIO1): reg_sel = EIV_REG_PRIO1;
      (ADDR_W-2)'(`EIV_IDX_PRIO2): reg_sel = EIV_REG_PRIO2;
      (ADDR_W-2)'(`EIV_IDX_PRIO3): reg_sel = EIV_REG_PRIO3;
      (ADDR_W-2)'(`EIV_IDX_SENSE): reg_sel = EIV_REG_SENSE;
      (ADDR_W-2)'(`EIV_IDX_STATUS): reg_sel = EIV_REG_STATUS;
      (ADDR_W-2)'(`EIV_IDX_MASK): reg_sel = EIV_REG_MASK;
      default: reg_sel = EIV_REG_NONE;
    endcase
  end

  assign apb_commit = PSEL & PENABLE & pready;
  assign wr = apb_commit & PWRITE;
  assign sense_wr_ok = CORE_COND_CODE == `EIV_CORE_LOCKED;
  assign sense_new = PWDATA[7:0] & `EIV_SENSE_WMASK;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (reg_sel)
      EIV_REG_PRIO0: next_prdata[7:0] = prio[0];
      EIV_REG_PRIO1: next_prdata[7:0] = prio[1];
      EIV_REG_PRIO2: next_prdata[7:0] = prio[2];
      EIV_REG_PRIO3: next_prdata[7:0] = prio[3];
      EIV_REG_SENSE: next_prdata[7:0] = pin_irq_sense_ctrl;
      EIV_REG_STATUS: next_prdata[3:0] = irq_status;
      EIV_REG_MASK: next_prdata[3:0] = irq_mask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      pready <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      pready <= PSEL & PENABLE & ~pready;
      if (PSEL & PENABLE & ~pready)
      begin
        PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
        PSLVERR <= reg_sel == EIV_REG_NONE;
      end
      else
      begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end
  assign PREADY = pready;

  // ----------------------------------------------------------------
  // software priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      for (int k = 0; k < 4; k++)
      begin
        prio[k] <= `EIV_PRIO_RESET;
      end
    end
    else if (wr)
    begin
      case (reg_sel)
        EIV_REG_PRIO0: prio[0] <= prio_write(prio[0], PWDATA[7:0], `EIV_PRIO0_FIXED);
        EIV_REG_PRIO1: prio[1] <= prio_write(prio[1], PWDATA[7:0], `EIV_PRIO_NOFIX);
        EIV_REG_PRIO2: prio[2] <= prio_write(prio[2], PWDATA[7:0], `EIV_PRIO_NOFIX);
        EIV_REG_PRIO3: prio[3] <= prio_write(prio[3], PWDATA[7:0], `EIV_PRIO3_FIXED);
        default: prio[0] <= prio[0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sense control and pin sampling
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      pin_irq_sense_ctrl <= `EIV_SENSE_RESET;
    end
    else if (wr && reg_sel == EIV_REG_SENSE && sense_wr_ok)
    begin
      pin_irq_sense_ctrl <= sense_new;
    end
  end

  assign pins = {PORTB_HIGH_LINE, PORTB_LOW_LINE, PORTF_LINE, PORTA_LINE};

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      // history follows the pins so a pin idling high gives no false edge
      pin_prev <= pins;
    end
    else
    begin
      pin_prev <= pins;
    end
  end

  always_comb
  begin
    eiv_sense_t pa_code;
    eiv_sense_t pb_code;
    logic pa_inv;
    logic pb_inv;
    pa_code = eiv_sense_t'(pin_irq_sense_ctrl[`EIV_PA_SENSE_HI:`EIV_PA_SENSE_LO]);
    pb_code = eiv_sense_t'(pin_irq_sense_ctrl[`EIV_PB_SENSE_HI:`EIV_PB_SENSE_LO]);
    pa_inv = pin_irq_sense_ctrl[`EIV_PA_INV];
    pb_inv = pin_irq_sense_ctrl[`EIV_PB_INV];
    ext_edge[0] = edge_hit(pa_code, pa_inv, pins[0], pin_prev[0]);
    ext_edge[1] = edge_hit(pa_code, 1'b0, pins[1], pin_prev[1]);
    ext_edge[2] = edge_hit(pb_code, pb_inv, pins[2], pin_prev[2]);
    ext_edge[3] = edge_hit(pb_code, 1'b0, pins[3], pin_prev[3]);
    // level part of code 00 requests for as long as the pin stays active
    ext_level[0] = (pa_code == EIV_SENSE_FALL_LOW) & (pa_inv ? pins[0] : ~pins[0]);
    ext_level[1] = (pa_code == EIV_SENSE_FALL_LOW) & ~pins[1];
    ext_level[2] = (pb_code == EIV_SENSE_FALL_LOW) & (pb_inv ? pins[2] : ~pins[2]);
    ext_level[3] = (pb_code == EIV_SENSE_FALL_LOW) & ~pins[3];
    sense_clr = 4'h0;
    if (wr && reg_sel == EIV_REG_SENSE && sense_wr_ok)
    begin
      sense_clr[0] = (sense_new[4:2] != pin_irq_sense_ctrl[4:2]);
      sense_clr[1] = (sense_new[4:3] != pin_irq_sense_ctrl[4:3]);
      sense_clr[2] = (sense_new[7:5] != pin_irq_sense_ctrl[7:5]);
      sense_clr[3] = (sense_new[7:6] != pin_irq_sense_ctrl[7:6]);
    end
  end

  // a fresh edge in the clearing cycle survives the clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      ext_pend <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (ext_edge[i])
        begin
          ext_pend[i] <= 1'b1;
        end
        else if (sense_clr[i] || (IRQ_ACK && IRQ_REQ && irq_src == 4'(i + 1)))
        begin
          ext_pend[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  assign req = {AUX_VOLTAGE_REQ, SCI_REQ, TIMER_B_REQ, TIMER_A_REQ, SPI_REQ,
                ext_pend | ext_level, CLK_TIME_BASE_REQ};

  always_comb
  begin
    src_pair[0] = prio[0][3:2];
    src_pair[1] = prio[0][5:4];
    src_pair[2] = prio[0][7:6];
    src_pair[3] = prio[1][1:0];
    src_pair[4] = prio[1][3:2];
    src_pair[5] = prio[1][7:6];
    src_pair[6] = prio[2][1:0];
    src_pair[7] = prio[2][3:2];
    src_pair[8] = prio[2][5:4];
    src_pair[9] = prio[2][7:6];
  end

  // scan from the highest index downward so a tie goes to the earlier source
  always_comb
  begin
    found = 1'b0;
    best_lvl = 2'd0;
    best_src = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i] && (!found || level_of(src_pair[i]) >= best_lvl))
      begin
        found = 1'b1;
        best_lvl = level_of(src_pair[i]);
        best_src = 4'(i);
      end
    end
    take = found && (best_lvl > level_of(CORE_COND_CODE));
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      IRQ_REQ <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
      IRQ_LEVEL <= 2'b11;
      irq_src <= 4'h0;
    end
    else
    begin
      IRQ_REQ <= take;
      IRQ_VECTOR <= take ? vec_of(best_src) : 16'h0000;
      IRQ_LEVEL <= take ? src_pair[best_src] : 2'b11;
      irq_src <= best_src;
    end
  end

  // halt wake ignores core priority: the core forces level 0 on halt
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      WAKE_REQ <= 1'b0;
    end
    else
    begin
      WAKE_REQ <= |(req & `EIV_WAKE_SET);
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------
  always_comb
  begin
    next_status = (ext_edge | ext_level) |
                  (irq_status & ~((wr && reg_sel == EIV_REG_STATUS) ? PWDATA[3:0] : 4'h0));
    next_mask = (wr && reg_sel == EIV_REG_MASK) ? PWDATA[3:0] : irq_mask;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      irq_mask <= next_mask;
      IRQ <= |(next_status & next_mask);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  a_portb_rise_only: assert property (
    pin_irq_sense_ctrl[7:5] == 3'b010 && !pin_prev[2] && PORTB_LOW_LINE |=> ext_pend[2])
    else $error("port B low rising edge missed");
  a_portb_inverted: assert property (
    pin_irq_sense_ctrl[7:5] == 3'b011 && pin_prev[2] && !PORTB_LOW_LINE |=> ext_pend[2])
    else $error("port B low inverted falling edge missed");
  a_portb_high_noinv: assert property (
    pin_irq_sense_ctrl[7:5] == 3'b101 && !pin_prev[3] && PORTB_HIGH_LINE |-> !ext_edge[3])
    else $error("port B high took inversion");
  a_porta_level: assert property (
    pin_irq_sense_ctrl[4:2] == 3'b001 && PORTA_LINE |-> req[1])
    else $error("port A inverted high level not requesting");
  a_portf_both: assert property (
    pin_irq_sense_ctrl[4:3] == 2'b11 && pin_prev[1] != PORTF_LINE |=> ext_pend[1])
    else $error("port F edge missed");
  a_prio_reset: assert property (
    $past(!RSTN) |-> prio[0] == 8'hff && prio[1] == 8'hff && prio[2] == 8'hff)
    else $error("priority reset value wrong");
  a_prio_fixed: assert property (
    prio[0][1:0] == 2'b11 && prio[3][7:4] == 4'hf)
    else $error("unassigned priority bits not one");
  a_clk_tb_first: assert property (
    CLK_TIME_BASE_REQ && src_pair[0] == 2'b11 && CORE_COND_CODE != 2'b11
    |=> IRQ_REQ && IRQ_VECTOR == 16'hfff8)
    else $error("clock time base not served first");
  a_avd_last: assert property (
    req == 10'h200 && prio[2] == 8'hff && CORE_COND_CODE == 2'b10
    |=> IRQ_REQ && IRQ_VECTOR == 16'hffe4 && IRQ_LEVEL == 2'b11)
    else $error("voltage detector vector wrong");
  a_no_wake_timers: assert property (
    (req & 10'h03f) == 10'h000 |=> !WAKE_REQ)
    else $error("wake from non-waking source");
  a_wake_spi: assert property (
    SPI_REQ || ext_pend != 4'h0 |=> WAKE_REQ)
    else $error("waking source did not wake");
  a_sense_lock: assert property (
    wr && reg_sel == EIV_REG_SENSE && CORE_COND_CODE != 2'b11 |=> $stable(pin_irq_sense_ctrl))
    else $error("sense written while unlocked");
  a_sense_clear: assert property (
    wr && reg_sel == EIV_REG_SENSE && sense_wr_ok && sense_new[7:6] != pin_irq_sense_ctrl[7:6]
    && !ext_edge[3] |=> !ext_pend[3])
    else $error("pending not cleared on sense change");
  a_level0_reject: assert property (
    wr && reg_sel == EIV_REG_PRIO1 && PWDATA[1:0] == 2'b10 |=> $stable(prio[1][1:0]))
    else $error("level 0 priority accepted");
  a_irq_line: assert property (
    !(wr && reg_sel == EIV_REG_MASK) && |((ext_edge | ext_level) & irq_mask) |=> IRQ)
    else $error("unmasked event did not raise interrupt");
  a_apb_ready: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");

  c_sense_write: cover property (wr && reg_sel == EIV_REG_SENSE && sense_wr_ok);
  c_ack_served: cover property (IRQ_REQ && IRQ_ACK);
  c_wake: cover property (WAKE_REQ && !IRQ_REQ);
  c_inverted_pend: cover property (ext_pend[0] && pin_irq_sense_ctrl[2]);

endmodule

// >>> tb/eiv_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// core side: priority level and vector ack
// ----------------------------------------
module eiv_core_model
#(
  parameter int ACK_DELAY = 3
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic [1:0] level_set,
  output logic [1:0] core_cond_code,
  output logic irq_ack
);
  int cnt;

  // software only edits sense bits while this level is 11
  assign core_cond_code = level_set;

  // a slow core: the request must stand a while before it is taken
  always_ff @(posedge clk)
  begin
    if (!rstn || !irq_req || !ack_en || irq_ack)
    begin
      cnt <= 0;
      irq_ack <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      irq_ack <= (cnt == ACK_DELAY);
    end
  end
endmodule

// >>> tb/ext_irq_sense_vector_map_tb_top.sv
`timescale 1ns/100ps
`include "eiv_defines.svh"
module ext_irq_sense_vector_map_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, irq_req, wake_req, irq, irq_ack, err;
  logic [31:0] prdata;
  logic [15:0] irq_vector;
  logic [1:0] irq_level, core_cc;
  logic [1:0] core_lvl = 2'b11;
  logic [3:0] pins = 4'h0;
  logic [5:0] reqs = 6'h00;
  logic ack_en = 1'b0;
  logic [7:0] rd;
  int fails = 0;
  int samples_checked = 0;
  int e;
  logic [15:0] vt [6] = '{`EIV_VEC_CLK_TB, `EIV_VEC_SPI, `EIV_VEC_TIMER_A,
                          `EIV_VEC_TIMER_B, `EIV_VEC_SCI, `EIV_VEC_AUX_VD};

  eiv_ctrl u_eiv_ctrl (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .PORTA_LINE(pins[3]), .PORTF_LINE(pins[2]),
    .PORTB_LOW_LINE(pins[1]), .PORTB_HIGH_LINE(pins[0]), .CORE_COND_CODE(core_cc),
    .CLK_TIME_BASE_REQ(reqs[5]), .SPI_REQ(reqs[4]), .TIMER_A_REQ(reqs[3]),
    .TIMER_B_REQ(reqs[2]), .SCI_REQ(reqs[1]), .AUX_VOLTAGE_REQ(reqs[0]),
    .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector),
    .IRQ_LEVEL(irq_level), .WAKE_REQ(wake_req), .IRQ(irq));

  eiv_core_model u_eiv_core_model (.clk(clk_sys), .rstn(rstn), .irq_req(irq_req),
    .ack_en(ack_en), .level_set(core_lvl), .core_cond_code(core_cc), .irq_ack(irq_ack));

  initial forever #5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      $display("[FAIL] %0t apb answer timed out", $time);
      finish_test();
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask

  task automatic setp(input logic [3:0] v);
    @(posedge clk_sys);
    pins <= v;
  endtask

  // expected event on one line for a pin move p0 -> p1
  function automatic logic fires(input logic [1:0] c, input logic inv, input logic p0,
                                 input logic p1);
    logic r, f;
    r = inv ? (p0 & ~p1) : (~p0 & p1);
    f = inv ? (~p0 & p1) : (p0 & ~p1);
    case (c)
      2'b00: return f | (p0 == inv) | (p1 == inv);
      2'b01: return r;
      2'b10: return f;
      default: return r | f;
    endcase
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #300000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    cyc(16);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) rdc(`EIV_IDX_PRIO0 + 8'(k), 8'hff);
    rdc(`EIV_IDX_SENSE, 8'h00);
    apb(1'b0, 8'h2b, 8'h00);
    chk(err, 1'b1);
    wr(`EIV_IDX_PRIO0, 8'h64);
    rdc(`EIV_IDX_PRIO0, 8'h77);
    wr(`EIV_IDX_PRIO1, 8'hfe);
    rdc(`EIV_IDX_PRIO1, 8'hff);
    wr(`EIV_IDX_PRIO3, 8'h00);
    rdc(`EIV_IDX_PRIO3, 8'hf0);
    wr(`EIV_IDX_PRIO0, 8'hff);
    core_lvl <= 2'b00;
    wr(`EIV_IDX_SENSE, 8'hfc);
    rdc(`EIV_IDX_SENSE, 8'h00);
    core_lvl <= 2'b11;
    wr(`EIV_IDX_SENSE, 8'hff);
    rdc(`EIV_IDX_SENSE, 8'hfc);
    // every code, both polarities, both pin directions
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 2; i++)
        for (int d = 0; d < 2; d++)
        begin
          wr(`EIV_IDX_SENSE, {2'(c), 1'(i), 2'(c), 1'(i), 2'b00});
          setp({4{1'(d)}});
          cyc(4);
          wr(`EIV_IDX_STATUS, 8'h0f);
          setp({4{~1'(d)}});
          cyc(4);
          apb(1'b0, `EIV_IDX_STATUS, 8'h00);
          e = 2 * fires(2'(c), 1'(i), 1'(d), ~1'(d)) + 2 * fires(2'(c), 1'b0, 1'(d), ~1'(d));
          chk(16'($countones(rd[3:0])), 16'(e));
        end
    // status, mask and interrupt line
    wr(`EIV_IDX_SENSE, 8'h48);
    wr(`EIV_IDX_STATUS, 8'h0f);
    setp(4'hf);
    cyc(4);
    chk(irq, 1'b0);
    wr(`EIV_IDX_MASK, 8'h0f);
    cyc(2);
    chk(irq, 1'b1);
    rdc(`EIV_IDX_MASK, 8'h0f);
    wr(`EIV_IDX_STATUS, 8'h0f);
    cyc(2);
    chk(irq, 1'b0);
    // pending rising edges must vanish with the sense change
    wr(`EIV_IDX_SENSE, 8'h90);
    core_lvl <= 2'b10;
    cyc(4);
    chk(irq_req, 1'b0);
    setp(4'he);
    cyc(4);
    chk(irq_vector, `EIV_VEC_PORTB_HIGH);
    chk(wake_req, 1'b1);
    chk(irq_level, 2'b11);
    @(posedge clk_sys);
    ack_en <= 1'b1;
    cyc(10);
    chk(irq_req, 1'b0);
    chk(wake_req, 1'b0);
    ack_en <= 1'b0;
    // fixed order among equal priorities, wake capability
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_sys);
      reqs <= 6'h3f >> k;
      cyc(3);
      chk(irq_vector, vt[k]);
      chk(wake_req, 1'(k < 2));
    end
    wr(`EIV_IDX_PRIO0, 8'h57);
    wr(`EIV_IDX_PRIO1, 8'h55);
    wr(`EIV_IDX_PRIO2, 8'h75);
    rdc(`EIV_IDX_PRIO1, 8'h55);
    @(posedge clk_sys);
    reqs <= 6'h3f;
    cyc(3);
    chk(irq_vector, `EIV_VEC_SCI);
    chk(irq_level, 2'b11);
    core_lvl <= 2'b11;
    cyc(3);
    chk(irq_req, 1'b0);
    finish_test();
  end
endmodule
